/* File: core/hcr_pkg.sv */
// shared constants and types for the host port routing control block
package hcr_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0]  ADDR_HOST_PORT_DATA   = 8'h10;
  localparam logic [7:0]  ADDR_BOOT_CONTROL     = 8'h14;
  localparam logic [7:0]  ADDR_ROUTING_CONFIG   = 8'h20;

  // -----------------------------------------------------------------
  // routing config fields and reset
  // -----------------------------------------------------------------
  localparam int          CFG_SEL_LO_BIT        = 0;
  localparam int          CFG_SEL_HI_BIT        = 1;
  localparam int          CFG_BUF_CABLE_BIT     = 2;
  localparam int          CFG_HOST_CABLE_BIT    = 3;
  localparam int          CFG_BUF_EN_BIT        = 4;
  localparam int          CFG_HOST_EN_BIT       = 5;
  localparam logic [7:0]  CFG_RESET             = 8'h2C;

  // -----------------------------------------------------------------
  // boot control fields and reset
  // -----------------------------------------------------------------
  localparam int          CTL_RESET_BIT         = 0;
  localparam int          CTL_IRQ0_BIT          = 1;
  localparam int          CTL_NMI_N_BIT         = 4;
  localparam int          CTL_IRQ_COUNT         = 3;
  localparam logic [4:0]  CTL_RESET             = 5'h1F;

  // -----------------------------------------------------------------
  // status fields
  // -----------------------------------------------------------------
  localparam int          STS_OUTPUT_FULL_BIT   = 16;
  localparam int          STS_INPUT_FULL_BIT    = 17;

  // -----------------------------------------------------------------
  // module port numbers reachable by the buffered port
  // -----------------------------------------------------------------
  localparam logic [2:0]  PORT_SEL_00           = 3'h0;
  localparam logic [2:0]  PORT_SEL_01           = 3'h2;
  localparam logic [2:0]  PORT_SEL_10           = 3'h3;
  localparam logic [2:0]  PORT_SEL_11           = 3'h5;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    HCR_IDLE = 2'b00,
    HCR_SEND = 2'b01,
    HCR_RECV = 2'b10
  } hcr_link_state_t;

  typedef struct packed {
    logic       port3_switch_on;
    logic       host_logic_en;
    logic       host_to_flat;
    logic       buffer_route_en;
    logic       buffer_to_flat;
    logic [2:0] buffer_port;
  } hcr_route_t;

  typedef struct packed {
    logic       module_reset;
    logic [2:0] module_irq_line;
    logic       module_nmi_n;
  } hcr_boot_t;

endpackage

/* File: core/hcr_routing_ctrl.sv */
// host port, routing config and module boot control logic
// -------------------------------------------------------------------
// -------------------------------------------------------------------
`timescale 1ns/100ps

module hcr_routing_ctrl #(
  parameter int WORD_WIDTH = 32
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_clock_en,
  // register access
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [31:0]           i_reg_wdata,
  output logic      [31:0]           o_reg_rdata,
  output logic                       o_reg_rvalid,
  // straps and cable detects from pins
  input  wire logic                  i_host_cable_detect_n,
  input  wire logic                  i_buffer_cable_detect_n,
  input  wire logic                  i_direct_link_strap,
  // word link to module port 3
  input  wire logic                  i_dsp_rx_req,
  input  wire logic                  i_dsp_rx_valid,
  input  wire logic [WORD_WIDTH-1:0] i_dsp_rx_data,
  output logic                       o_dsp_rx_ready,
  output logic                       o_dsp_tx_valid,
  output logic      [WORD_WIDTH-1:0] o_dsp_tx_data,
  input  wire logic                  i_dsp_tx_ack,
  output logic                       o_host_port_dir,
  // routing switches
  output hcr_pkg::hcr_route_t        o_route,
  // buffered connector
  input  wire logic                  i_buffer_dir_valid,
  input  wire logic                  i_buffer_dir_tx,
  output logic                       o_buffer_dir,
  output logic                       o_buffer_reset_out,
  output logic                       o_buffer_reset_oe_n,
  // module site boot control
  output hcr_pkg::hcr_boot_t         o_boot
);

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic [4:0] pin_raw;

  assign pin_raw = {i_buffer_dir_tx, i_buffer_dir_valid,
                    i_direct_link_strap, i_buffer_cable_detect_n,
                    i_host_cable_detect_n};

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      pin_meta_reg <= 5'h03;
      pin_sync_reg <= 5'h03;
    end else if (i_clock_en) begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic host_cable_n;
  logic buffer_cable_n;
  logic strap_fitted;
  logic buf_dir_valid;
  logic buf_dir_tx;

  assign host_cable_n   = pin_sync_reg[0];
  assign buffer_cable_n = pin_sync_reg[1];
  assign strap_fitted   = pin_sync_reg[2];
  assign buf_dir_valid  = pin_sync_reg[3];
  assign buf_dir_tx     = pin_sync_reg[4];

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  logic wr_data;
  logic wr_ctrl;
  logic wr_cfg;
  logic rd_data;
  logic rd_ctrl;
  logic rd_cfg;

  assign wr_data = i_reg_wr && (i_reg_addr == hcr_pkg::ADDR_HOST_PORT_DATA);
  assign wr_ctrl = i_reg_wr && (i_reg_addr == hcr_pkg::ADDR_BOOT_CONTROL);
  assign wr_cfg  = i_reg_wr && (i_reg_addr == hcr_pkg::ADDR_ROUTING_CONFIG);
  assign rd_data = i_reg_rd && (i_reg_addr == hcr_pkg::ADDR_HOST_PORT_DATA);
  assign rd_ctrl = i_reg_rd && (i_reg_addr == hcr_pkg::ADDR_BOOT_CONTROL);
  assign rd_cfg  = i_reg_rd && (i_reg_addr == hcr_pkg::ADDR_ROUTING_CONFIG);

  // -----------------------------------------------------------------
  // routing config register
  // -----------------------------------------------------------------
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] cfg_view;
  logic [7:0] cfg_wmask;

  // only enables and selects are writable
  assign cfg_wmask = 8'h33;
  assign cfg_next  = (cfg_reg & ~cfg_wmask) | (i_reg_wdata[7:0] & cfg_wmask);

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cfg_reg <= hcr_pkg::CFG_RESET;
    end else if (i_clock_en && wr_cfg) begin
      cfg_reg <= cfg_next;
    end
  end

  // live cable detects replace the stored copies on read
  always_comb begin
    cfg_view = cfg_reg & cfg_wmask;
    cfg_view[hcr_pkg::CFG_HOST_CABLE_BIT] = host_cable_n;
    cfg_view[hcr_pkg::CFG_BUF_CABLE_BIT]  = buffer_cable_n;
  end

  // -----------------------------------------------------------------
  // routing decode
  // -----------------------------------------------------------------
  function automatic logic [2:0] port_of_sel(input logic [1:0] sel);
    logic [2:0] port;
    port = hcr_pkg::PORT_SEL_00;
    unique case (sel)
      2'b00: port = hcr_pkg::PORT_SEL_00;
      2'b01: port = hcr_pkg::PORT_SEL_01;
      2'b10: port = hcr_pkg::PORT_SEL_10;
      2'b11: port = hcr_pkg::PORT_SEL_11;
    endcase
    return port;
  endfunction

  logic       host_en_bit;
  logic       buf_en_bit;
  logic [1:0] sel_bits;
  logic       host_active;

  assign host_en_bit = cfg_reg[hcr_pkg::CFG_HOST_EN_BIT];
  assign buf_en_bit  = cfg_reg[hcr_pkg::CFG_BUF_EN_BIT];
  assign sel_bits    = cfg_reg[hcr_pkg::CFG_SEL_HI_BIT:hcr_pkg::CFG_SEL_LO_BIT];
  assign host_active = !strap_fitted;

  logic       route_p3_on;
  logic       route_host_flat;
  logic       route_buf_en;
  logic       route_buf_flat;

  assign route_p3_on     = strap_fitted || (host_cable_n && host_en_bit);
  assign route_host_flat = host_active && !host_cable_n;
  assign route_buf_en    = buffer_cable_n && buf_en_bit;
  assign route_buf_flat  = !buffer_cable_n;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_route <= '0;
    end else if (i_clock_en) begin
      o_route.port3_switch_on <= route_p3_on;
      o_route.host_logic_en   <= host_active;
      o_route.host_to_flat    <= route_host_flat;
      o_route.buffer_route_en <= route_buf_en;
      o_route.buffer_to_flat  <= route_buf_flat;
      o_route.buffer_port     <= port_of_sel(sel_bits);
    end
  end

  // -----------------------------------------------------------------
  // buffered port direction
  // -----------------------------------------------------------------
  logic buf_dir_reg;
  logic buf_dir_next;

  // any routing config write restores the reset direction of the selected port
  assign buf_dir_next = wr_cfg ? !i_reg_wdata[hcr_pkg::CFG_SEL_HI_BIT] :
                        buf_dir_valid ? buf_dir_tx : buf_dir_reg;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      buf_dir_reg <= !hcr_pkg::CFG_RESET[hcr_pkg::CFG_SEL_HI_BIT];
    end else if (i_clock_en) begin
      buf_dir_reg <= buf_dir_next;
    end
  end

  assign o_buffer_dir = buf_dir_reg;

  // -----------------------------------------------------------------
  // boot control register
  // -----------------------------------------------------------------
  logic [4:0] ctl_reg;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      ctl_reg <= hcr_pkg::CTL_RESET;
    end else if (i_clock_en && wr_ctrl) begin
      ctl_reg <= i_reg_wdata[4:0];
    end
  end

  assign o_boot.module_reset    = ctl_reg[hcr_pkg::CTL_RESET_BIT];
  assign o_boot.module_irq_line =
    ctl_reg[hcr_pkg::CTL_IRQ0_BIT +: hcr_pkg::CTL_IRQ_COUNT];
  assign o_boot.module_nmi_n    = ctl_reg[hcr_pkg::CTL_NMI_N_BIT];

  // open collector: pull low while module reset is driven
  assign o_buffer_reset_out  = 1'b0;
  assign o_buffer_reset_oe_n = !ctl_reg[hcr_pkg::CTL_RESET_BIT];

  // -----------------------------------------------------------------
  // host port word registers and flags
  // -----------------------------------------------------------------
  hcr_pkg::hcr_link_state_t state_reg;
  hcr_pkg::hcr_link_state_t state_next;

  logic [WORD_WIDTH-1:0] out_word_reg;
  logic [WORD_WIDTH-1:0] in_word_reg;
  logic                  output_full_flag;
  logic                  input_full_flag;
  logic                  host_load;
  logic                  word_sent;
  logic                  word_taken;

  assign host_load  = wr_data && !output_full_flag && host_active;
  assign word_sent  = (state_reg == hcr_pkg::HCR_SEND) && i_dsp_tx_ack;
  assign word_taken = (state_reg == hcr_pkg::HCR_RECV) && i_dsp_rx_valid
                      && !input_full_flag;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      out_word_reg     <= '0;
      in_word_reg      <= '0;
      output_full_flag <= 1'b0;
      input_full_flag  <= 1'b0;
    end else if (i_clock_en) begin
      if (host_load) begin
        out_word_reg <= i_reg_wdata[WORD_WIDTH-1:0];
      end
      if (word_taken) begin
        in_word_reg <= i_dsp_rx_data;
      end
      output_full_flag <= host_load || (output_full_flag && !word_sent);
      input_full_flag  <= word_taken || (input_full_flag && !rd_data);
    end
  end

  // -----------------------------------------------------------------
  // link direction control
  // -----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      hcr_pkg::HCR_IDLE: begin
        if (host_active && i_dsp_rx_req && !input_full_flag) begin
          state_next = hcr_pkg::HCR_RECV;
        end else if (host_active && output_full_flag) begin
          state_next = hcr_pkg::HCR_SEND;
        end
      end
      hcr_pkg::HCR_SEND: begin
        if (i_dsp_tx_ack || !host_active) begin
          state_next = hcr_pkg::HCR_IDLE;
        end
      end
      hcr_pkg::HCR_RECV: begin
        // dropped request without a full word is discarded
        if (word_taken || !i_dsp_rx_req || !host_active) begin
          state_next = hcr_pkg::HCR_IDLE;
        end
      end
      default: begin
        state_next = hcr_pkg::HCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_reg <= hcr_pkg::HCR_IDLE;
    end else if (i_clock_en) begin
      state_reg <= state_next;
    end
  end

  assign o_dsp_tx_valid  = (state_reg == hcr_pkg::HCR_SEND);
  assign o_dsp_tx_data   = out_word_reg;
  assign o_dsp_rx_ready  = (state_reg == hcr_pkg::HCR_RECV)
                           && !input_full_flag;
  assign o_host_port_dir = (state_reg == hcr_pkg::HCR_SEND);

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  always_comb begin
    status_word = '0;
    status_word[hcr_pkg::STS_OUTPUT_FULL_BIT] = output_full_flag;
    status_word[hcr_pkg::STS_INPUT_FULL_BIT]  = input_full_flag;
  end

  // boot control is write only: its offset returns status
  assign rd_mux = rd_data ? 32'(in_word_reg) :
                  rd_ctrl ? status_word :
                  rd_cfg  ? {24'h000000, cfg_view} : 32'h00000000;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end else if (i_clock_en) begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

endmodule

/* File: verif/hcr_routing_ctrl_sva.sv */
// assertion checker for the host port routing control block
`timescale 1ns/100ps
module hcr_routing_ctrl_sva #(
  parameter int WORD_WIDTH = 32
) (
  input wire logic                  i_clock,
  input wire logic                  i_reset_n,
  input wire logic                  i_clock_en,
  input wire logic [7:0]            i_reg_addr,
  input wire logic                  i_reg_wr,
  input wire logic                  i_reg_rd,
  input wire logic [31:0]           i_reg_wdata,
  input wire logic                  o_reg_rvalid,
  input wire logic                  i_dsp_rx_valid,
  input wire logic                  o_dsp_rx_ready,
  input wire logic                  o_dsp_tx_valid,
  input wire logic [WORD_WIDTH-1:0] o_dsp_tx_data,
  input wire logic                  i_dsp_tx_ack,
  input wire logic                  o_host_port_dir,
  input wire hcr_pkg::hcr_route_t   o_route,
  input wire logic                  o_buffer_dir,
  input wire logic                  o_buffer_reset_out,
  input wire logic                  o_buffer_reset_oe_n,
  input wire hcr_pkg::hcr_boot_t    o_boot
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  wire cfg_wr = i_reg_wr && i_clock_en &&
                i_reg_addr == hcr_pkg::ADDR_ROUTING_CONFIG;
  wire rx_take = o_dsp_rx_ready && i_dsp_rx_valid && i_clock_en;

  a_read_answer: assert property (i_reg_rd && i_clock_en |=> o_reg_rvalid)
    else $error("read strobe without answer");
  a_tx_hold: assert property (o_dsp_tx_valid && !i_dsp_tx_ack |=>
    o_dsp_tx_valid && $stable(o_dsp_tx_data))
    else $error("outgoing word not held until ack");
  a_rx_once: assert property (rx_take |=> !o_dsp_rx_ready [*2])
    else $error("second word taken before host read");
  a_dir_send: assert property (o_dsp_tx_valid |-> o_host_port_dir)
    else $error("host port not turned to transmit");
  a_reset_copy: assert property (!o_buffer_reset_out &&
    (o_buffer_reset_oe_n == !o_boot.module_reset))
    else $error("reset out does not copy module reset");
  a_rel_reset: assert property ($rose(i_reset_n) |-> o_boot.module_reset)
    else $error("module reset not held by system reset");
  a_cfg_dir: assert property (cfg_wr |=>
    o_buffer_dir == !$past(i_reg_wdata[1]))
    else $error("buffered direction ignores upper select");
  a_route_sel: assert property (o_route.buffer_route_en |->
    o_route.buffer_port inside {3'h0, 3'h2, 3'h3, 3'h5})
    else $error("buffered port outside selectable set");
  a_strap_quiet: assert property (!o_route.host_logic_en |->
    !o_dsp_tx_valid && !o_dsp_rx_ready)
    else $error("host port active while disabled");

  c_rx_take: cover property (rx_take);
  c_tx_ack: cover property (o_dsp_tx_valid && i_dsp_tx_ack);
  c_cfg_wr: cover property (cfg_wr);
endmodule

/* File: verif/hcr_dsp_model.sv */
// behavioural model of the module port 3 word link
`timescale 1ns/100ps
module hcr_dsp_model (
  input  wire logic        i_clock,
  input  wire logic        i_send,
  input  wire logic [31:0] i_word,
  input  wire logic [3:0]  i_ack_delay,
  input  wire logic        i_rx_ready,
  input  wire logic        i_tx_valid,
  input  wire logic [31:0] i_tx_data,
  output logic             o_rx_req,
  output logic             o_rx_valid,
  output logic [31:0]      o_rx_data,
  output logic             o_tx_ack,
  output logic [31:0]      o_got,
  output int               o_got_n
);
  logic        pend = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  cnt = 4'h0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 32'h0;
    o_tx_ack = 1'b0;
    o_got = 32'h0;
    o_got_n = 0;
  end
  assign o_rx_req = pend;
  // request held until the word is taken
  always @(posedge i_clock) begin
    if (i_send) begin
      pend <= 1'b1;
      wd <= i_word;
    end else if (o_rx_valid)
      pend <= 1'b0;
  end
  // one complete word per transfer, line scrambled when released
  always @(negedge i_clock) begin
    if (o_rx_valid) begin
      o_rx_valid <= 1'b0;
      o_rx_data <= ~o_rx_data;
    end else if (pend && i_rx_ready) begin
      o_rx_valid <= 1'b1;
      o_rx_data <= wd;
    end
    if (!i_tx_valid || o_tx_ack) begin
      o_tx_ack <= 1'b0;
      cnt <= 4'h0;
    end
    else if (cnt == i_ack_delay) begin
      o_tx_ack <= 1'b1;
      o_got <= i_tx_data;
      o_got_n <= o_got_n + 1;
    end else
      cnt <= cnt + 4'h1;
  end
endmodule

/* File: verif/hcr_routing_ctrl_tb.sv */
// self-checking testbench for the host port routing control block
`timescale 1ns/100ps
module hcr_routing_ctrl_tb;
  typedef struct packed {
    logic [7:0] wd;
    logic       en;
    logic [2:0] port;
    logic [7:0] rd;
  } hcr_row_t;
  localparam hcr_row_t ROWS [5] = '{
    '{8'h10, 1'h1, 3'h0, 8'h1C}, '{8'h11, 1'h1, 3'h2, 8'h1D},
    '{8'h32, 1'h1, 3'h3, 8'h3E}, '{8'hD3, 1'h1, 3'h5, 8'h1F},
    '{8'h2F, 1'h0, 3'h5, 8'h2F}};
  localparam logic [7:0] AD = hcr_pkg::ADDR_HOST_PORT_DATA;
  localparam logic [7:0] AC = hcr_pkg::ADDR_BOOT_CONTROL;
  localparam logic [7:0] AR = hcr_pkg::ADDR_ROUTING_CONFIG;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        hcd_n = 1'b1;
  logic        bcd_n = 1'b1;
  logic        strap = 1'b0;
  logic        dv = 1'b0;
  logic        dtx = 1'b0;
  logic        send = 1'b0;
  logic [31:0] word = 32'h0;
  logic [3:0]  dly = 4'h5;
  logic [31:0] rdata, rx_data, tx_data, got;
  logic        rvalid, rx_req, rx_valid, rx_ready, tx_valid, tx_ack;
  logic        hdir, bdir, rout, roe_n;
  hcr_pkg::hcr_route_t route;
  hcr_pkg::hcr_boot_t  boot;
  int          got_n;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  always #10 clk = ~clk;

  hcr_routing_ctrl i_hcr_routing_ctrl (
    .i_clock(clk), .i_reset_n(rst_n), .i_clock_en(1'h1),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_host_cable_detect_n(hcd_n), .i_buffer_cable_detect_n(bcd_n),
    .i_direct_link_strap(strap), .i_dsp_rx_req(rx_req),
    .i_dsp_rx_valid(rx_valid), .i_dsp_rx_data(rx_data),
    .o_dsp_rx_ready(rx_ready), .o_dsp_tx_valid(tx_valid),
    .o_dsp_tx_data(tx_data), .i_dsp_tx_ack(tx_ack),
    .o_host_port_dir(hdir), .o_route(route), .i_buffer_dir_valid(dv),
    .i_buffer_dir_tx(dtx), .o_buffer_dir(bdir),
    .o_buffer_reset_out(rout), .o_buffer_reset_oe_n(roe_n), .o_boot(boot));

  hcr_dsp_model i_hcr_dsp_model (
    .i_clock(clk), .i_send(send), .i_word(word), .i_ack_delay(dly),
    .i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_rx_req(rx_req), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_tx_ack(tx_ack), .o_got(got), .o_got_n(got_n));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk1("rvalid", 1'b1, rvalid);
    chk("rdata", e, rdata);
  endtask

  task automatic dsp_send(input logic [31:0] w);
    @(negedge clk);
    word = w;
    send = 1'b1;
    @(negedge clk);
    send = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk1("mod_reset", 1'b1, boot.module_reset);
    chk1("reset_oe_n", 1'b0, roe_n);
    repeat (3) @(negedge clk);
    rd_reg(AR, 32'h2C);
    chk1("p3_switch", 1'b1, route.port3_switch_on);
    chk1("buf_dir", 1'b1, bdir);
    foreach (ROWS[k]) begin
      wr_reg(AR, {24'h0, ROWS[k].wd});
      repeat (2) @(negedge clk);
      rd_reg(AR, {24'h0, ROWS[k].rd});
      chk1("buf_en", ROWS[k].en, route.buffer_route_en);
      if (ROWS[k].en)
        chk("buf_port", 32'(ROWS[k].port), 32'(route.buffer_port));
      chk1("p3_switch", ROWS[k].wd[5], route.port3_switch_on);
      chk1("buf_dir", !ROWS[k].wd[1], bdir);
    end
    // boot flags, both writes leave the module released
    wr_reg(AC, 32'h0A);
    @(negedge clk);
    chk("boot", 32'h0A, 32'(boot));
    wr_reg(AC, 32'h1E);
    @(negedge clk);
    chk("boot", 32'h0F, 32'(boot));
    chk1("reset_oe_n", 1'b1, roe_n);
    chk1("reset_out", 1'b0, rout);
    rd_reg(AC, 32'h0);
    // host to module, second write while full is dropped
    wr_reg(AD, 32'hA5C3_0F96);
    rd_reg(AC, 32'h0001_0000);
    chk1("host_dir", 1'b1, hdir);
    wr_reg(AD, 32'h1234_5678);
    for (int k = 0; k < 40 && got_n < 1; k++)
      @(negedge clk);
    repeat (4) @(negedge clk);
    chk("tx_word", 32'hA5C3_0F96, got);
    chk("tx_count", 32'h1, 32'(got_n));
    chk1("host_dir", 1'b0, hdir);
    rd_reg(AC, 32'h0);
    // module to host, second word waits for the host read
    dsp_send(32'h0F0F_1234);
    rd_reg(AC, 32'h0002_0000);
    dsp_send(32'hC001_D00D);
    chk1("rx_ready", 1'b0, rx_ready);
    rd_reg(AD, 32'h0F0F_1234);
    repeat (8) @(negedge clk);
    rd_reg(AD, 32'hC001_D00D);
    rd_reg(AC, 32'h0);
    // cable detects
    hcd_n = 1'b0;
    bcd_n = 1'b0;
    repeat (5) @(negedge clk);
    rd_reg(AR, 32'h23);
    chk1("host_flat", 1'b1, route.host_to_flat);
    chk1("p3_switch", 1'b0, route.port3_switch_on);
    chk1("buf_en", 1'b0, route.buffer_route_en);
    chk1("buf_flat", 1'b1, route.buffer_to_flat);
    hcd_n = 1'b1;
    bcd_n = 1'b1;
    // strap overrides a cleared link enable and blocks data writes
    strap = 1'b1;
    wr_reg(AR, 32'h10);
    repeat (5) @(negedge clk);
    chk1("p3_switch", 1'b1, route.port3_switch_on);
    chk1("host_logic", 1'b0, route.host_logic_en);
    chk1("buf_en", 1'b1, route.buffer_route_en);
    wr_reg(AD, 32'h5555_AAAA);
    rd_reg(AC, 32'h0);
    strap = 1'b0;
    // direction pins
    dv = 1'b1;
    repeat (5) @(negedge clk);
    chk1("buf_dir", 1'b0, bdir);
    dtx = 1'b1;
    repeat (5) @(negedge clk);
    chk1("buf_dir", 1'b1, bdir);
    dv = 1'b0;
    rd_reg(8'h30, 32'h0);
    // second reset in mid-run
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk1("mod_reset", 1'b1, boot.module_reset);
    repeat (3) @(negedge clk);
    rd_reg(AR, 32'h2C);
    close_out();
  end
endmodule

bind hcr_routing_ctrl hcr_routing_ctrl_sva #(.WORD_WIDTH(WORD_WIDTH))
  i_hcr_routing_ctrl_sva (.*);
